/* design/tagged_exec_regs.vh */
// Constants for the tagged arithmetic, swap and aux register executor
`ifndef TAGGED_EXEC_REGS_VH
`define TAGGED_EXEC_REGS_VH
// ==========================================================
// Instruction fields
`define OP_HI          31
`define OP_LO          30
`define RD_HI          29
`define RD_LO          25
`define OP3_HI         24
`define OP3_LO         19
`define RS1_HI         18
`define RS1_LO         14
`define IBIT           13
`define ASI_HI         12
`define ASI_LO         5
`define RS2_HI         4
`define RS2_LO         0
`define SIMM_HI        12
// ==========================================================
// Opcode values
`define OP_MEM         2'h3
`define OP_ARITH       2'h2
`define OP3_SWAP_ALT   6'h1F
`define OP3_TADD_TV    6'h22
`define OP3_TSUB_TV    6'h23
`define OP3_AUX_WR     6'h30
`define RD_AUX         5'h00
`define ASI_PRIV_BIT   7
// ==========================================================
// Condition code positions (xcc high nibble, icc low nibble)
`define CC_N           3
`define CC_Z           2
`define CC_V           1
`define CC_C           0
// ==========================================================
// Reset values and timing
`define CCR_RESET      8'h00
`define AUX_RESET      32'h00000000
`define MEM_WAIT_MAX   8'hFF
`endif

/* design/tagged_alu.v */
// Tagged add/subtract datapath with tag overflow and flag generation
`timescale 1ns/1ps
module tagged_alu (
  input  wire [63:0] a,
  input  wire [63:0] b,
  input  wire        sub,
  output wire [63:0] result,
  output wire        tag_ovf,
  output wire [7:0]  ccr_val
);
`include "tagged_exec_regs.vh"

  wire [63:0] b_eff;
  wire [64:0] sum;
  wire [32:0] low;
  wire        v32;
  wire        v64;
  wire        c32;
  wire        c64;

  assign b_eff  = sub ? ~b : b;
  assign sum    = {1'b0, a} + {1'b0, b_eff} + {64'h0, sub};
  assign low    = {1'b0, a[31:0]} + {1'b0, b_eff[31:0]} + {32'h0, sub};
  assign result = sum[63:0];
  // Carry inverts to borrow on subtract
  assign c32    = low[32] ^ sub;
  assign c64    = sum[64] ^ sub;

  // Signed overflow; for subtract b_eff already flips the sign of b
  assign v32 = (a[31] == b_eff[31]) && (result[31] != a[31]);
  assign v64 = (a[63] == b_eff[63]) && (result[63] != a[63]);

  assign tag_ovf = (|a[1:0]) | (|b[1:0]) | v32;

  // The 32-bit overflow flag is forced low; only commits when no trap
  assign ccr_val = {result[63], (result == 64'h0), v64, c64,
                    result[31], (result[31:0] == 32'h0), 1'b0,
                    c32};

endmodule // tagged_alu

/* design/tagged_exec.v */
// Executor for alternate swap, tagged add/sub with trap, aux reg write
// Operation
// - Swap decoded when top field 11 and subfield 011111.
// - Swap exchanges low word with memory; upper half of result zero.
// - Swap read and write are indivisible; no interrupts in between.
// - Concurrent atomics to one doubleword are serialized in some order.
// - Space id from instruction when immediate bit 0, register when 1.
// - Space id bit 7 low is privileged; unprivileged use faults.
// - Swap address is A plus B, or A plus sign-extended immediate.
// - Swap address not a multiple of four raises misalignment.
// - Tagged add decoded by subfield 100010; A plus B or immediate.
// - Tag overflow on nonzero low two bits or 32-bit signed overflow.
// - Tagged add overflow traps; destination and flags untouched.
// - Tagged add otherwise writes sum, clears 32-bit V, normal flags.
// - Tagged add 64-bit V from ordinary 64-bit overflow only.
// - Tagged ops trap only on 32-bit tag overflow, never 64-bit.
// - Tagged subtract decoded by subfield 100011; A minus B/immediate.
// - Subtract tag overflow: low bits, or sign mismatch overflow.
// - Subtract overflow traps unchanged; else writes, clears 32-bit V.
// - Tagged subtract 64-bit V from ordinary subtract overflow only.
// - Aux write: top 10, subfield 110000, destination 0 only.
// - Aux write stores A xor B, or A xor sign-extended immediate.
// - Aux write visible to the very next instruction.
`timescale 1ns/1ps
module tagged_exec (
  input  wire        CLK,
  input  wire        RESET,
  // Issue port
  input  wire        ISSUE_VALID,
  output wire        ISSUE_READY,
  input  wire [31:0] INSTR,
  input  wire [63:0] SRC_A,
  input  wire [63:0] SRC_B,
  // Current destination register value, swapped out to memory
  input  wire [63:0] DEST_DATA,
  input  wire [7:0]  ASI_REG,
  input  wire        PRIVILEGE_BIT,
  // Write-back and traps
  output reg         WB_VALID,
  output reg  [4:0]  WB_ADDR,
  output reg  [63:0] WB_DATA,
  output reg         CCR_WE,
  output reg  [7:0]  CONDITION_CODE_REGISTER,
  output reg         AUX_MUL_REG_WRITE,
  output reg  [31:0] AUX_MUL_REG,
  output reg         DONE,
  output reg         TRAP_TAG_OVF,
  output reg         TRAP_PRIV,
  output reg         TRAP_ALIGN,
  output reg         TRAP_ILLEGAL,
  output wire        ATOMIC_BUSY,
  // Atomic swap port to memory
  output reg         MEM_REQ,
  output reg  [63:0] MEM_ADDR,
  output reg  [7:0]  MEM_ASI,
  output reg  [31:0] MEM_WDATA,
  output reg         MEM_LOCK,
  input  wire        MEM_GRANT,
  input  wire        MEM_ACK,
  input  wire [31:0] MEM_RDATA
);
`include "tagged_exec_regs.vh"

  // ==========================================================
  // State encoding
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_REQ  = 2'h1;
  localparam [1:0] ST_WAIT = 2'h2;

  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg  [4:0]  swap_rd_r;
  reg  [7:0]  wait_cnt_r;

  // ==========================================================
  // Decode
  wire [1:0]  op_field        = INSTR[`OP_HI:`OP_LO];
  wire [5:0]  opcode_subfield = INSTR[`OP3_HI:`OP3_LO];
  wire [4:0]  dest            = INSTR[`RD_HI:`RD_LO];
  wire        imm_sel         = INSTR[`IBIT];
  wire [12:0] signed_immediate_field = INSTR[`SIMM_HI:0];
  wire [63:0] simm_ext = {{51{signed_immediate_field[12]}},
                          signed_immediate_field};
  wire [63:0] source_a = SRC_A;
  wire [63:0] source_b = imm_sel ? simm_ext : SRC_B;

  wire is_swap = (op_field == `OP_MEM) &&
                 (opcode_subfield == `OP3_SWAP_ALT);
  wire is_tadd = (op_field == `OP_ARITH) &&
                 (opcode_subfield == `OP3_TADD_TV);
  wire is_tsub = (op_field == `OP_ARITH) &&
                 (opcode_subfield == `OP3_TSUB_TV);
  wire is_wr   = (op_field == `OP_ARITH) &&
                 (opcode_subfield == `OP3_AUX_WR);
  wire is_aux  = is_wr && (dest == `RD_AUX);
  // Other destinations belong to another state-register writer
  wire is_other_wr = is_wr && (dest != `RD_AUX);

  // ==========================================================
  // Swap address, space id and checks
  wire [63:0] eff_addr = source_a + source_b;
  wire [7:0]  asi = imm_sel ? ASI_REG
                            : INSTR[`ASI_HI:`ASI_LO];
  wire        priv_fault = ~asi[`ASI_PRIV_BIT] & ~PRIVILEGE_BIT;
  wire        align_fault = |eff_addr[1:0];

  // ==========================================================
  // Tagged arithmetic
  wire [63:0] alu_result;
  wire        tag_ovf;
  wire [7:0]  alu_ccr;

  tagged_alu u_alu (
    .a       (source_a),
    .b       (source_b),
    .sub     (is_tsub),
    .result  (alu_result),
    .tag_ovf (tag_ovf),
    .ccr_val (alu_ccr)
  );

  // ==========================================================
  // Issue handshake: stall while the swap owns the memory port
  assign ISSUE_READY = (state_r == ST_IDLE);
  // Interrupt logic outside holds off while this is high
  assign ATOMIC_BUSY = (state_r != ST_IDLE);

  wire take = ISSUE_VALID && ISSUE_READY;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (take && is_swap && !priv_fault && !align_fault) begin
          state_nxt = ST_REQ;
        end
      end
      ST_REQ: begin
        // Memory arbiter grants one locked swap at a time
        if (MEM_GRANT) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (MEM_ACK) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge CLK) begin
    if (RESET) begin
      state_r    <= ST_IDLE;
      swap_rd_r  <= 5'h00;
      wait_cnt_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      if (take && is_swap) begin
        swap_rd_r <= dest;
      end
      // Diagnostic count of cycles spent waiting, saturates
      if (state_r == ST_IDLE) begin
        wait_cnt_r <= 8'h00;
      end else if (wait_cnt_r != `MEM_WAIT_MAX) begin
        wait_cnt_r <= wait_cnt_r + 8'h01;
      end
    end
  end

  // ==========================================================
  // Memory side: request held until grant, lock held until the answer
  always @(posedge CLK) begin
    if (RESET) begin
      MEM_REQ   <= 1'b0;
      MEM_ADDR  <= 64'h0;
      MEM_ASI   <= 8'h00;
      MEM_WDATA <= 32'h0;
      MEM_LOCK  <= 1'b0;
    end else begin
      if (take && is_swap && !priv_fault && !align_fault) begin
        MEM_REQ   <= 1'b1;
        MEM_ADDR  <= eff_addr;
        MEM_ASI   <= asi;
        MEM_WDATA <= DEST_DATA[31:0];
        MEM_LOCK  <= 1'b1;
      end else if (state_r == ST_REQ && MEM_GRANT) begin
        MEM_REQ <= 1'b0;
      end else if (state_r == ST_WAIT && MEM_ACK) begin
        MEM_LOCK <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Results, flags, traps
  always @(posedge CLK) begin
    if (RESET) begin
      WB_VALID                <= 1'b0;
      WB_ADDR                 <= 5'h00;
      WB_DATA                 <= 64'h0;
      CCR_WE                  <= 1'b0;
      CONDITION_CODE_REGISTER <= `CCR_RESET;
      AUX_MUL_REG_WRITE       <= 1'b0;
      AUX_MUL_REG             <= `AUX_RESET;
      DONE                    <= 1'b0;
      TRAP_TAG_OVF            <= 1'b0;
      TRAP_PRIV               <= 1'b0;
      TRAP_ALIGN              <= 1'b0;
      TRAP_ILLEGAL            <= 1'b0;
    end else begin
      WB_VALID          <= 1'b0;
      CCR_WE            <= 1'b0;
      AUX_MUL_REG_WRITE <= 1'b0;
      DONE              <= 1'b0;
      TRAP_TAG_OVF      <= 1'b0;
      TRAP_PRIV         <= 1'b0;
      TRAP_ALIGN        <= 1'b0;
      TRAP_ILLEGAL      <= 1'b0;
      if (state_r == ST_WAIT && MEM_ACK) begin
        // Old memory word lands zero-extended in the destination
        WB_VALID <= (swap_rd_r != 5'h00);
        WB_ADDR  <= swap_rd_r;
        WB_DATA  <= {32'h0, MEM_RDATA};
        DONE     <= 1'b1;
      end else if (take) begin
        if (is_swap) begin
          // Privilege checked ahead of alignment
          TRAP_PRIV  <= priv_fault;
          TRAP_ALIGN <= ~priv_fault & align_fault;
          DONE       <= priv_fault | align_fault;
        end else if (is_tadd || is_tsub) begin
          DONE <= 1'b1;
          if (tag_ovf) begin
            TRAP_TAG_OVF <= 1'b1;
          end else begin
            WB_VALID                <= (dest != 5'h00);
            WB_ADDR                 <= dest;
            WB_DATA                 <= alu_result;
            CCR_WE                  <= 1'b1;
            CONDITION_CODE_REGISTER <= alu_ccr;
          end
        end else if (is_aux) begin
          // Registered in this cycle, so the next issue sees it
          AUX_MUL_REG_WRITE <= 1'b1;
          AUX_MUL_REG       <= source_a[31:0] ^ source_b[31:0];
          DONE              <= 1'b1;
        end else begin
          // Not ours, including other state-register writes
          TRAP_ILLEGAL <= 1'b1;
          DONE         <= 1'b1;
        end
      end
    end
  end

endmodule // tagged_exec

/* bench/tagged_exec_checker.sv */
// Port assertions for the tagged executor
`timescale 1ns/1ps
module tagged_exec_checker (
  input wire        CLK,
  input wire        RESET,
  input wire        ISSUE_READY,
  input wire        PRIVILEGE_BIT,
  input wire        WB_VALID,
  input wire [4:0]  WB_ADDR,
  input wire [63:0] WB_DATA,
  input wire        CCR_WE,
  input wire [7:0]  CONDITION_CODE_REGISTER,
  input wire        AUX_MUL_REG_WRITE,
  input wire [31:0] AUX_MUL_REG,
  input wire        DONE,
  input wire        TRAP_TAG_OVF,
  input wire        TRAP_ALIGN,
  input wire        ATOMIC_BUSY,
  input wire        MEM_REQ,
  input wire [63:0] MEM_ADDR,
  input wire [7:0]  MEM_ASI,
  input wire        MEM_ACK,
  input wire        MEM_LOCK
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  // Marks a swap in flight so its write-back can be told apart
  reg swap_r;
  always @(posedge CLK)
    if (RESET || DONE) swap_r <= 1'b0;
    else if (MEM_REQ) swap_r <= 1'b1;
  sequence s_ack;
    ATOMIC_BUSY && MEM_ACK;
  endsequence
  AST_ACK_DONE: assert property (s_ack |-> ##1 DONE && !MEM_LOCK)
    else $error("swap not finished after answer");
  AST_BUSY: assert property (MEM_REQ |-> ATOMIC_BUSY && !ISSUE_READY)
    else $error("issue open during atomic access");
  AST_ALIGNED: assert property (MEM_REQ |-> MEM_ADDR[1:0] == 2'h0)
    else $error("misaligned address sent to memory");
  AST_PRIV: assert property (MEM_REQ && !PRIVILEGE_BIT |-> MEM_ASI[7])
    else $error("privileged space used unprivileged");
  AST_TRAP_QUIET: assert property (TRAP_TAG_OVF |-> !WB_VALID && !CCR_WE)
    else $error("tag trap with write-back");
  AST_ICC_V: assert property (CCR_WE |-> !CONDITION_CODE_REGISTER[1])
    else $error("32-bit overflow flag set");
  AST_SWAP_HI: assert property (WB_VALID && swap_r |-> WB_DATA[63:32] == 32'h0)
    else $error("swap upper word not zero");
  AST_RD0: assert property (WB_VALID |-> WB_ADDR != 5'h00)
    else $error("write-back to register zero");
  AST_AUX_CHG: assert property ($changed(AUX_MUL_REG)
    |-> AUX_MUL_REG_WRITE || $past(AUX_MUL_REG_WRITE))
    else $error("aux register changed without write");
  AST_ALIGN_NOMEM: assert property (TRAP_ALIGN |-> !MEM_REQ && !WB_VALID)
    else $error("misaligned swap went ahead");
endmodule // tagged_exec_checker
bind tagged_exec tagged_exec_checker tagged_exec_checker_inst (.*);

/* bench/swap_mem_model.sv */
// Memory model answering atomic swap requests
`timescale 1ns/1ps
module swap_mem_model (
  input  wire        clk,
  input  wire        reset,
  input  wire        req,
  input  wire [63:0] addr,
  input  wire [31:0] wdata,
  output reg         grant,
  output reg         ack,
  output reg  [31:0] rdata,
  output reg  [31:0] last_rd,
  output reg  [63:0] last_addr
);
  reg [31:0] mem [0:255];
  reg [2:0]  wait_r;
  reg        pend;
  integer    i;
  initial begin
    grant = 1'b0;
    ack = 1'b0;
    rdata = 32'h0;
    wait_r = 3'h0;
    for (i = 0; i < 256; i = i + 1) mem[i] = 32'hC3A50000 + i;
  end
  always @(posedge clk) begin
    grant <= 1'b0;
    ack <= 1'b0;
    // Bus released: toggle so stale data never looks valid
    rdata <= ~rdata;
    if (reset) begin
      pend <= 1'b0;
      wait_r <= 3'h0;
    end else if (pend) begin
      // Address and data stay held by the requester until the answer
      if (wait_r == 3'h0) begin
        ack <= 1'b1;
        rdata <= mem[addr[9:2]];
        mem[addr[9:2]] <= wdata;
        last_rd <= mem[addr[9:2]];
        last_addr <= addr;
        pend <= 1'b0;
      end else wait_r <= wait_r - 3'h1;
    end else if (req && !grant) begin
      // Grant first, answer after a variable wait
      grant <= 1'b1;
      pend <= 1'b1;
      wait_r <= addr[4:2];
    end
  end
endmodule // swap_mem_model

/* bench/tagged_exec_tb_top.sv */
// Self-checking bench for the tagged executor
`timescale 1ns/1ps
`include "tagged_exec_regs.vh"
module tagged_exec_tb_top;
  reg         CLK = 0, RESET = 1, ISSUE_VALID = 0, PRIVILEGE_BIT = 0;
  reg  [31:0] INSTR = 32'h0;
  reg  [63:0] SRC_A = 64'h0, SRC_B = 64'h0, DEST_DATA = 64'h0;
  reg  [7:0]  ASI_REG = 8'h0;
  wire        ISSUE_READY, WB_VALID, CCR_WE, AUX_MUL_REG_WRITE, DONE;
  wire        TRAP_TAG_OVF, TRAP_PRIV, TRAP_ALIGN, TRAP_ILLEGAL;
  wire        ATOMIC_BUSY, MEM_REQ, MEM_LOCK, MEM_GRANT, MEM_ACK;
  wire [4:0]  WB_ADDR;
  wire [7:0]  CONDITION_CODE_REGISTER, MEM_ASI;
  wire [31:0] AUX_MUL_REG, MEM_WDATA, MEM_RDATA, last_rd;
  wire [63:0] WB_DATA, MEM_ADDR, last_addr;
  integer     error_cnt = 0, cmp_count = 0, cyc = 0, k, j;
  reg  [7:0]  ccq = `CCR_RESET;
  reg  [31:0] auxq = `AUX_RESET;
  tagged_exec tagged_exec_inst (.*);
  swap_mem_model swap_mem_model_inst (.clk(CLK), .reset(RESET),
    .req(MEM_REQ), .addr(MEM_ADDR), .wdata(MEM_WDATA), .grant(MEM_GRANT),
    .ack(MEM_ACK), .rdata(MEM_RDATA), .last_rd(last_rd),
    .last_addr(last_addr));
  always #2.5 CLK = ~CLK;
  // ====
  // Checking and closing
  task give_verdict;
    begin
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input [63:0] got, input [63:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  always @(posedge CLK) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      give_verdict;
    end
  end
  // ====
  // One instruction: 0 add, 1 subtract, 2 swap, 3 aux write
  task step(input [1:0] k, input imm, input [4:0] rd, input [1:0] f);
    reg [63:0] a, b, r;
    reg [12:0] s;
    reg [7:0]  ai, aq, cc;
    reg [5:0]  o3;
    reg        sb, c32, c64, v32, v64, t, pv, pt, mis;
    integer    n;
    begin
      a = {$urandom, $urandom};
      s = $urandom;
      ai = $urandom;
      aq = $urandom;
      pv = $urandom;
      mis = (k == 2) && (f == 2'h0);
      if (k < 2 && f != 2'h0) begin
        a[1:0] = 2'h0;
        s[1:0] = 2'h0;
      end
      b = imm ? {{51{s[12]}}, s} : {$urandom, $urandom};
      if (k < 2 && f != 2'h0) b[1:0] = 2'h0;
      r = a + b;
      if (k == 2) a = a - {62'h0, r[1:0]} + {62'h0, mis, 1'b0};
      if (mis) pv = 1'b1;
      sb = (k == 1);
      r = sb ? a - b : a + b;
      c64 = sb ? a < b : r < a;
      c32 = sb ? a[31:0] < b[31:0] : r[31:0] < a[31:0];
      v64 = ((a[63] ^ b[63]) == sb) && (r[63] != a[63]);
      v32 = ((a[31] ^ b[31]) == sb) && (r[31] != a[31]);
      t = (|a[1:0]) || (|b[1:0]) || v32;
      cc = {r[63], r == 64'h0, v64, c64, r[31], r[31:0] == 32'h0, 1'b0, c32};
      o3 = (k == 0) ? `OP3_TADD_TV : (k == 1) ? `OP3_TSUB_TV :
           (k == 2) ? `OP3_SWAP_ALT : `OP3_AUX_WR;
      @(negedge CLK);
      INSTR <= {(k == 2) ? `OP_MEM : `OP_ARITH, rd, o3, 5'($urandom), imm,
                imm ? s : {ai, 5'($urandom)}};
      SRC_A <= a;
      SRC_B <= b;
      DEST_DATA <= {$urandom, $urandom};
      ASI_REG <= aq;
      PRIVILEGE_BIT <= pv;
      ISSUE_VALID <= 1'b1;
      n = 0;
      do @(posedge CLK); while (ISSUE_READY !== 1'b1 && ++n < 200);
      @(negedge CLK);
      ISSUE_VALID <= 1'b0;
      while (DONE !== 1'b1 && n < 400) begin
        @(negedge CLK);
        n = n + 1;
      end
      chk(DONE, 1);
      if (k < 2) begin
        chk(TRAP_TAG_OVF, t);
        chk(CCR_WE, !t);
        chk(CONDITION_CODE_REGISTER, t ? ccq : cc);
        if (!t) ccq = cc;
        chk(WB_VALID, !t && rd != 5'h0);
        if (!t && rd != 5'h0) chk(WB_ADDR, rd);
        if (!t && rd != 5'h0) chk(WB_DATA, r);
      end else if (k == 2) begin
        pt = !(imm ? aq[7] : ai[7]) && !pv;
        chk(TRAP_PRIV, pt);
        chk(TRAP_ALIGN, mis);
        chk(WB_VALID, !pt && !mis && rd != 5'h0);
        if (!pt && !mis) chk(last_addr, a + b);
        if (!pt && !mis) chk(MEM_WDATA, DEST_DATA[31:0]);
        chk(MEM_LOCK, 0);
        if (!pt && !mis && rd != 5'h0) chk(WB_DATA, {32'h0, last_rd});
      end else begin
        chk(AUX_MUL_REG_WRITE, rd == 5'h0);
        chk(TRAP_ILLEGAL, rd != 5'h0);
        if (rd == 5'h0) auxq = a[31:0] ^ b[31:0];
        chk(AUX_MUL_REG, auxq);
      end
    end
  endtask
  initial begin
    void'($urandom(81));
    repeat (3) @(posedge CLK);
    @(negedge CLK);
    RESET <= 1'b0;
    for (k = 0; k < 4; k = k + 1) begin
      for (j = 0; j < 50; j = j + 1)
        step(k, $urandom, ($urandom % 4 == 0) ? 5'h0 : 5'($urandom),
             2'($urandom));
      $display("test kind %0d done", k);
    end
    give_verdict;
  end
endmodule // tagged_exec_tb_top
